// ===== hw/trc_map.vh
// register offsets, fields, reset values and mode codes of the timer block
`ifndef TRC_MAP_VH
`define TRC_MAP_VH

`define TRC_TSC_OFF      8'h00
`define TRC_CNTH_OFF     8'h04
`define TRC_CNTL_OFF     8'h08
`define TRC_MODH_OFF     8'h0c
`define TRC_MODL_OFF     8'h10
`define TRC_CSC_OFF      8'h14
`define TRC_CVH_OFF      8'h18
`define TRC_CVL_OFF      8'h1c
`define TRC_DBG_OFF      8'h20

`define TRC_TSC_PS_LSB   0
`define TRC_TSC_PS_MSB   2
`define TRC_TSC_CS_LSB   3
`define TRC_TSC_CS_MSB   4
`define TRC_CSC_MS_LSB   4
`define TRC_CSC_MS_MSB   5

`define TRC_MODE_CAPTURE 2'h0
`define TRC_MODE_COMPARE 2'h1

`define TRC_TSC_RESET    8'h00
`define TRC_CSC_RESET    8'h00
`define TRC_MOD_RESET    16'hffff
`define TRC_CV_RESET     16'h0000

`endif

// ===== hw/trc_prescaler.v
// prescaler divider producing the counter advance enable
`timescale 1ns/1ps
module trc_prescaler #(
    parameter WIDTH = 7
) (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       run_i,
    input  wire       clear_i,
    input  wire [2:0] tap_i,
    output reg        tick_o
);
    reg [WIDTH-1:0] div;
    wire [WIDTH-1:0] mask;

    assign mask = (({{(WIDTH-1){1'b0}}, 1'b1} << tap_i) - 1'b1);

    always @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            div    <= {WIDTH{1'b0}};
            tick_o <= 1'b0;
        end else if (run_i) begin
            tick_o <= ((div & mask) == mask);
            div    <= ((div & mask) == mask) ? {WIDTH{1'b0}} : div + 1'b1;
        end else begin
            tick_o <= 1'b0;
        end
    end
endmodule

// ===== hw/trc_byte_latch.v
// read-coherency buffer for one 16-bit value read as two bytes
`timescale 1ns/1ps
module trc_byte_latch (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        clear_i,
    input  wire        bypass_i,
    input  wire        rd_hi_i,
    input  wire        rd_lo_i,
    input  wire [15:0] live_i,
    output wire [7:0]  hi_o,
    output wire [7:0]  lo_o,
    output wire        held_o
);
    reg [7:0] buf_byte;
    reg       held_hi;
    reg       held_lo;

    always @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            held_hi  <= 1'b0;
            held_lo  <= 1'b0;
            buf_byte <= 8'h00;
        end else if (!bypass_i) begin
            if (rd_hi_i && !held_lo) begin
                buf_byte <= live_i[7:0];
                held_hi  <= 1'b1;
            end else if (rd_lo_i && !held_hi) begin
                buf_byte <= live_i[15:8];
                held_lo  <= 1'b1;
            end else if (rd_hi_i || rd_lo_i) begin
                held_hi <= 1'b0;
                held_lo <= 1'b0;
            end
        end
    end

    assign hi_o   = (!bypass_i && held_lo) ? buf_byte : live_i[15:8];
    assign lo_o   = (!bypass_i && held_hi) ? buf_byte : live_i[7:0];
    assign held_o = held_hi | held_lo;
endmodule

// ===== hw/trc_timer.v
// timer counter and channel value registers with read coherency
//
// Behaviour
// - writing either counter byte zeroes the counter and the prescaler.
// - in debug halt a counter byte read returns the frozen live count.
// - in debug halt a write to status/control or a counter byte clears the counter latch.
// - in debug halt a channel byte read returns the real channel value.
// - in debug halt a write to channel status/control clears its latch.
// - in input capture mode channel value writes are ignored.
// - in compare mode with a clock, the channel loads at the next tick after its second byte.
`timescale 1ns/1ps
`include "trc_map.vh"
module trc_timer #(
    parameter PS_WIDTH = 7
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    input  wire        debug_halt_state_i,
    input  wire        capture_i,
    output reg         compare_o
);
    ////////////////////////////////////////////////////////////////////
    reg  [7:0]  timer_status_control;
    reg  [7:0]  channel_status_control;
    reg  [15:0] timer_count_value;
    reg  [15:0] modulo;
    reg  [15:0] channel_value;
    reg  [15:0] cv_wbuf;
    reg         cv_hi_done;
    reg         cv_pending;
    reg  [31:0] next_dat;

    wire        req;
    wire        wr;
    wire        rd;
    wire        lane0;
    wire [1:0]  clk_sel;
    wire [2:0]  ps_tap;
    wire [1:0]  ch_mode;
    wire        tick;
    wire        cnt_wr;
    wire        cnt_clr_latch;
    wire        cv_clr_latch;
    wire [7:0]  cnt_hi;
    wire [7:0]  cnt_lo;
    wire [7:0]  cv_hi;
    wire [7:0]  cv_lo;
    wire        cnt_held;
    wire        cv_held;

    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    assign req     = cyc_i && stb_i && !ack_o;
    assign lane0   = sel_i[0];
    // a write commits at the edge where the master samples ack
    assign wr      = cyc_i && stb_i && we_i && ack_o && lane0;
    assign rd      = req && !we_i;
    assign clk_sel = timer_status_control[`TRC_TSC_CS_MSB:`TRC_TSC_CS_LSB];
    assign ps_tap  = timer_status_control[`TRC_TSC_PS_MSB:`TRC_TSC_PS_LSB];
    assign ch_mode = channel_status_control[`TRC_CSC_MS_MSB:`TRC_CSC_MS_LSB];
    assign cnt_wr  = wr && (hit(adr_i, `TRC_CNTH_OFF) ||
                            hit(adr_i, `TRC_CNTL_OFF));
    assign cnt_clr_latch = debug_halt_state_i &&
                           (cnt_wr || (wr && hit(adr_i, `TRC_TSC_OFF)));
    assign cv_clr_latch  = debug_halt_state_i && wr &&
                           hit(adr_i, `TRC_CSC_OFF);

    ////////////////////////////////////////////////////////////////////
    trc_prescaler #(
        .WIDTH (PS_WIDTH)
    ) u_ps (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .run_i   ((clk_sel != 2'b00) && !debug_halt_state_i),
        .clear_i (cnt_wr),
        .tap_i   (ps_tap),
        .tick_o  (tick)
    );

    trc_byte_latch u_cnt_latch (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .clear_i  (cnt_clr_latch),
        .bypass_i (debug_halt_state_i),
        .rd_hi_i  (rd && hit(adr_i, `TRC_CNTH_OFF)),
        .rd_lo_i  (rd && hit(adr_i, `TRC_CNTL_OFF)),
        .live_i   (timer_count_value),
        .hi_o     (cnt_hi),
        .lo_o     (cnt_lo),
        .held_o   (cnt_held)
    );

    trc_byte_latch u_cv_latch (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .clear_i  (cv_clr_latch),
        .bypass_i (debug_halt_state_i),
        .rd_hi_i  (rd && hit(adr_i, `TRC_CVH_OFF)),
        .rd_lo_i  (rd && hit(adr_i, `TRC_CVL_OFF)),
        .live_i   (channel_value),
        .hi_o     (cv_hi),
        .lo_o     (cv_lo),
        .held_o   (cv_held)
    );

    ////////////////////////////////////////////////////////////////////
    // counter
    always @(posedge clk_i) begin
        if (rst_i) begin
            timer_count_value <= 16'h0000;
        end else if (cnt_wr) begin
            timer_count_value <= 16'h0000;
        end else if (tick) begin
            if (timer_count_value == modulo)
                timer_count_value <= 16'h0000;
            else
                timer_count_value <= timer_count_value + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control registers and channel value write path
    always @(posedge clk_i) begin
        if (rst_i) begin
            timer_status_control   <= `TRC_TSC_RESET;
            channel_status_control <= `TRC_CSC_RESET;
            modulo                 <= `TRC_MOD_RESET;
            channel_value          <= `TRC_CV_RESET;
            cv_wbuf                <= `TRC_CV_RESET;
            cv_hi_done             <= 1'b0;
            cv_pending             <= 1'b0;
        end else begin
            if (wr && hit(adr_i, `TRC_TSC_OFF)) begin
                timer_status_control <= dat_i[7:0];
                cv_hi_done           <= 1'b0;
            end
            if (wr && hit(adr_i, `TRC_MODH_OFF))
                modulo[15:8] <= dat_i[7:0];
            if (wr && hit(adr_i, `TRC_MODL_OFF))
                modulo[7:0] <= dat_i[7:0];
            if (wr && hit(adr_i, `TRC_CSC_OFF))
                channel_status_control <= dat_i[7:0];
            if (ch_mode == `TRC_MODE_CAPTURE) begin
                cv_pending <= 1'b0;
                if (capture_i && !debug_halt_state_i)
                    channel_value <= timer_count_value;
            end else begin
                if (wr && hit(adr_i, `TRC_CVH_OFF)) begin
                    cv_wbuf[15:8] <= dat_i[7:0];
                    cv_hi_done    <= 1'b1;
                end
                if (wr && hit(adr_i, `TRC_CVL_OFF) && cv_hi_done) begin
                    cv_wbuf[7:0] <= dat_i[7:0];
                    cv_hi_done   <= 1'b0;
                    if (clk_sel == 2'b00)
                        channel_value <= {cv_wbuf[15:8], dat_i[7:0]};
                    else
                        cv_pending <= 1'b1;
                end else if (cv_pending && tick) begin
                    channel_value <= cv_wbuf;
                    cv_pending    <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux and bus answer, one wait state
    always @* begin
        next_dat = 32'h0000_0000;
        case (adr_i)
            `TRC_TSC_OFF:  next_dat[7:0] = timer_status_control;
            `TRC_CNTH_OFF: next_dat[7:0] = cnt_hi;
            `TRC_CNTL_OFF: next_dat[7:0] = cnt_lo;
            `TRC_MODH_OFF: next_dat[7:0] = modulo[15:8];
            `TRC_MODL_OFF: next_dat[7:0] = modulo[7:0];
            `TRC_CSC_OFF:  next_dat[7:0] = channel_status_control;
            `TRC_CVH_OFF:  next_dat[7:0] = cv_hi;
            `TRC_CVL_OFF:  next_dat[7:0] = cv_lo;
            `TRC_DBG_OFF:  next_dat[3:0] = {cv_pending, cv_held,
                                            cnt_held, debug_halt_state_i};
            default:       next_dat = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o     <= 1'b0;
            dat_o     <= 32'h0000_0000;
            compare_o <= 1'b0;
        end else begin
            ack_o     <= req;
            dat_o     <= rd ? next_dat : 32'h0000_0000;
            compare_o <= (ch_mode == `TRC_MODE_COMPARE) &&
                         (timer_count_value == channel_value);
        end
    end
endmodule

// ===== verification/trc_timer_asserts.sv
// port assertions of the timer register block
`timescale 1ns/1ps
module trc_timer_asserts (
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [7:0]  adr_i,
    input wire [3:0]  sel_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    input wire        debug_halt_state_i,
    input wire        compare_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire rd = ack_o && !we_i;
    wire hw = ack_o && we_i && sel_i[0] && debug_halt_state_i;
    wire nrd = rd && !debug_halt_state_i;
    reg  cclr;
    reg  vclr;
    // set by a halted clearing write, dropped by a normal byte read
    always @(posedge clk_i) begin
        if (rst_i || (nrd && (adr_i == 8'h04 || adr_i == 8'h08)))
            cclr <= 1'b0;
        else if (hw && (adr_i == 8'h00 || adr_i == 8'h04 || adr_i == 8'h08))
            cclr <= 1'b1;
        if (rst_i || (nrd && (adr_i == 8'h18 || adr_i == 8'h1c)))
            vclr <= 1'b0;
        else if (hw && adr_i == 8'h14)
            vclr <= 1'b1;
    end
    a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acked next cycle");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_idle_zero: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst_i |=> !ack_o && !compare_o && dat_o == 32'h0)
        else $error("outputs active after reset");
    a_gap_zero: assert property (rd && adr_i > 8'h20 |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_halt_flag: assert property (rd && adr_i == 8'h20
        |-> dat_o[0] == $past(debug_halt_state_i))
        else $error("halt flag wrong");
    a_cnt_clear: assert property (rd && adr_i == 8'h20 && cclr |-> !dat_o[1])
        else $error("count latch not cleared");
    a_chan_clear: assert property (rd && adr_i == 8'h20 && vclr |-> !dat_o[2])
        else $error("channel latch not cleared");
    c_cnt_write: cover property (hw && adr_i == 8'h08);
    c_halt_read: cover property (rd && debug_halt_state_i && adr_i == 8'h1c);
    c_compare: cover property ($rose(compare_o));
endmodule
bind trc_timer trc_timer_asserts u_chk (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_o, .ack_o, .debug_halt_state_i, .compare_o);

// ===== verification/trc_timer_tb_top.sv
// self-checking bench of the timer register block
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    mismatches++; $display("wrong value at %0t: %h %h", $time, a, b); end end
module trc_timer_tb_top;
    reg         clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, h = 0;
    reg         cap = 0;
    reg  [7:0]  adr_i = 0, q, l0, l1, l2, v, c;
    reg  [3:0]  sel_i = 1, sel = 1;
    reg  [31:0] dat_i = 0, seed = 48574;
    wire [31:0] dat_o;
    wire        ack_o, compare_o;
    int         mismatches = 0, comparisons = 0, n, i;
    reg  [7:0]  ra [7] = '{8'h00, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h24};
    reg  [7:0]  rv [7] = '{8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    reg  [7:0]  co [3] = '{8'h00, 8'h04, 8'h08};
    trc_timer #(.PS_WIDTH(7)) DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
        .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .debug_halt_state_i(h),
        .capture_i(cap), .compare_o);
    initial forever #5 clk_i = ~clk_i;
    function [7:0] rnd;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        rnd = seed[7:0];
    endfunction
    task finish_test;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task wb(input w, input [7:0] a, input [7:0] d);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i} <= {2'b11, w, a, sel};
        dat_i <= {24'h0, d};
        n = 0;
        do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
        q = dat_o[7:0];
        {cyc_i, stb_i} <= 2'b00;
        if (ack_o !== 1'b1) begin mismatches++; finish_test; end
    endtask
    task halt(input b);
        @(posedge clk_i) h <= b;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        sel = 4'he;
        wb(1, 8'h0c, 8'h00);
        sel = 4'h1;
        for (i = 0; i < 7; i++) begin wb(0, ra[i], 0); `CHK(q, rv[i]) end
        wb(1, 8'h18, rnd());
        wb(1, 8'h1c, rnd());
        wb(0, 8'h18, 0); `CHK(q, 8'h00)
        wb(0, 8'h1c, 0); `CHK(q, 8'h00)
        wb(1, 8'h00, 8'h1f);
        for (i = 0; i < 4; i++) begin
            repeat (rnd()) @(posedge clk_i);
            wb(1, 8'h08, rnd());
            // prescaler phase was random: only a cleared one stays quiet
            repeat (100) @(posedge clk_i);
            wb(0, 8'h04, 0); `CHK(q, 8'h00)
            wb(0, 8'h08, 0); `CHK(q, 8'h00)
        end
        repeat (300) @(posedge clk_i);
        // capture a running count, then try to overwrite it
        @(posedge clk_i) cap <= 1'b1;
        @(posedge clk_i) cap <= 1'b0;
        wb(0, 8'h1c, 0); c = q;
        `CHK(c != 8'h00, 1'b1)
        wb(1, 8'h18, rnd());
        wb(1, 8'h1c, ~c);
        wb(0, 8'h1c, 0); `CHK(q, c)
        wb(0, 8'h18, 0); `CHK(q, 8'h00)
        wb(0, 8'h08, 0); l0 = q;
        wb(0, 8'h04, 0);
        wb(0, 8'h04, 0);
        repeat (400) @(posedge clk_i);
        wb(0, 8'h08, 0); l1 = q;
        `CHK(l1 - l0 <= 8'h01, 1'b1)
        wb(0, 8'h04, 0);
        repeat (400) @(posedge clk_i);
        halt(1);
        wb(0, 8'h08, 0); l2 = q;
        `CHK(l2 - l1 >= 8'h02, 1'b1)
        wb(0, 8'h08, 0); `CHK(q, l2)
        for (i = 0; i < 3; i++) begin
            halt(0);
            wb(0, 8'h04, 0);
            wb(0, 8'h20, 0); `CHK(q[1], 1'b1)
            halt(1);
            wb(1, co[i], i == 0 ? 8'h1f : rnd());
            wb(0, 8'h20, 0); `CHK(q[1], 1'b0)
        end
        halt(0);
        wb(1, 8'h14, 8'h10);
        wb(1, 8'h08, 0);
        v = rnd();
        wb(1, 8'h18, 0);
        wb(1, 8'h1c, v);
        wb(0, 8'h20, 0); `CHK(q[3], 1'b1)
        wb(0, 8'h18, 0);
        wb(0, 8'h1c, 0); `CHK(q, c)
        repeat (200) @(posedge clk_i);
        wb(0, 8'h18, 0);
        wb(0, 8'h1c, 0); `CHK(q, v)
        wb(1, 8'h00, 8'h07);
        wb(0, 8'h18, 0);
        wb(1, 8'h18, 0);
        wb(1, 8'h1c, ~v);
        halt(1);
        wb(0, 8'h1c, 0); `CHK(q, ~v)
        halt(0);
        wb(0, 8'h1c, 0);
        wb(0, 8'h18, 0);
        wb(0, 8'h20, 0); `CHK(q[2], 1'b1)
        halt(1);
        wb(1, 8'h14, 8'h10);
        wb(0, 8'h20, 0); `CHK(q[2], 1'b0)
        halt(0);
        wb(1, 8'h18, 0);
        wb(1, 8'h1c, rnd() | 8'h40);
        wb(1, 8'h00, 8'h08);
        wb(1, 8'h08, 0);
        for (n = 0; n < 300 && compare_o !== 1'b1; n++) @(posedge clk_i);
        `CHK(compare_o, 1'b1)
        finish_test;
    end
endmodule
